// ---- vim_device.sv ----
/*
 * device end: input mode mux of the encoder. samples the pixel clocks
 * and buses, maps bus words onto SD and ED/HD channels per mode, and
 * holds the mode registers behind a plain register port.
 * assumes pixel data is stable two system clocks around each edge.
 */
`default_nettype none
`include "vim_map.svh"

module vim_device
    import vim_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst_n,
    // link
    vim_if.device link,
    // register port
    input wire logic [7:0] reg_addr,
    input var vim_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output vim_byte_type reg_rdata,
    // sd channels
    output vim_word_type sd_ch0,
    output vim_word_type sd_ch1,
    output vim_word_type sd_ch2,
    output logic sd_valid,
    output logic sd_hsync_n,
    output logic sd_vsync_n,
    output logic sd_ext_sync,
    // ed/hd channels
    output vim_word_type hd_ch0,
    output vim_word_type hd_ch1,
    output vim_word_type hd_ch2,
    output logic hd_valid,
    output logic hd_hsync_n,
    output logic hd_vsync_n,
    output logic hd_blank_n
);

    vim_dev_state_type q, d;

    // ==========================================================
    // helpers

    // map the mode field onto a mode
    function automatic vim_mode_type decode_mode(input logic [2:0] code);
        unique case (code)
            `VIM_CODE_SD: decode_mode = VIM_M_SD;
            `VIM_CODE_HD_SDR: decode_mode = VIM_M_HD_SDR;
            `VIM_CODE_HD_DDR: decode_mode = VIM_M_HD_DDR;
            `VIM_CODE_SD_HD_SDR: decode_mode = VIM_M_SD_HD_SDR;
            `VIM_CODE_SD_HD_DDR: decode_mode = VIM_M_SD_HD_DDR;
            `VIM_CODE_ED54: decode_mode = VIM_M_ED54;
            default: decode_mode = VIM_M_NONE;
        endcase
    endfunction : decode_mode

    // narrow mode keeps only the eight upper lines
    function automatic vim_word_type fit(input vim_word_type w,
                                         input logic ten);
        fit = ten ? w : {w[9:2], 2'b00};
    endfunction : fit

    // ==========================================================
    // decode of the current settings
    vim_mode_type mode;
    logic swap, sd_rgb, sd_wide, sd_ten;
    logic hd_rgb, hd_422, hd_ten, y_on_rise;
    logic pa_rise, pb_rise, pb_fall, pa_fall;
    logic sd_on, hd_on, hd_sec, hd_ddr, hd_rise, hd_fall;
    logic y_edge, c_edge;

    always_comb begin
        mode = decode_mode(q.mode_r[`VIM_MODE_MSB:`VIM_MODE_LSB]); // RULE_01 RULE_03
        swap = q.mode_r[`VIM_SWAP_BIT];
        y_on_rise = (q.mode_r[`VIM_EDGE_MSB:`VIM_EDGE_LSB]
                     == `VIM_EDGE_Y_RISE); // RULE_15 RULE_20
        sd_rgb = q.sd_ctl_r[`VIM_SD_RGB_BIT];
        sd_wide = q.sd_fmt_r[`VIM_SD_WIDE_BIT]; // RULE_10
        sd_ten = q.sd_fmt_r[`VIM_SD_WIDTH_BIT]; // RULE_10
        hd_rgb = q.hd_ctl_r[`VIM_HD_RGB_BIT];
        hd_422 = q.hd_fmt_r[`VIM_HD_422_BIT];
        hd_ten = q.hd_fmt_r[`VIM_HD_WIDTH_BIT]; // RULE_11
        // edges of the sampled pixel clocks
        pa_rise = q.pa[1] & ~q.pa[2];
        pa_fall = ~q.pa[1] & q.pa[2];
        pb_rise = q.pb[1] & ~q.pb[2];
        pb_fall = ~q.pb[1] & q.pb[2];
        // which paths run and on which clock
        sd_on = (mode == VIM_M_SD) || (mode == VIM_M_SD_HD_SDR) ||
                (mode == VIM_M_SD_HD_DDR);
        hd_sec = (mode == VIM_M_SD_HD_SDR) || (mode == VIM_M_SD_HD_DDR); // RULE_18
        hd_on = (mode != VIM_M_SD) && (mode != VIM_M_NONE);
        hd_ddr = (mode == VIM_M_HD_DDR) || (mode == VIM_M_SD_HD_DDR);
        hd_rise = hd_sec ? pb_rise : pa_rise;
        hd_fall = hd_sec ? pb_fall : pa_fall;
        y_edge = y_on_rise ? hd_rise : hd_fall;
        c_edge = y_on_rise ? hd_fall : hd_rise;
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.sd_valid = 1'b0;
        d.hd_valid = 1'b0;

        // two-flop synchronisers on every pin
        d.pa = {q.pa[1:0], link.primary_pixel_clock_in};
        d.pb = {q.pb[1:0], link.secondary_pixel_clock_in};
        d.s_m = link.s_bus;
        d.s_s = q.s_m;
        d.y_m = link.y_bus;
        d.y_s = q.y_m;
        d.c_m = link.c_bus;
        d.c_s = q.c_m;
        d.syn_m = {link.sd_hsync_n, link.sd_vsync_n,
                   link.hd_hsync_n, link.hd_vsync_n, link.hd_blank_n};
        d.syn_s = q.syn_m;

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `VIM_REG_MODE: d.mode_r = reg_wdata; // RULE_01
                `VIM_REG_HD_FMT: d.hd_fmt_r = reg_wdata;
                `VIM_REG_HD_CTL: d.hd_ctl_r = reg_wdata;
                `VIM_REG_SD_CTL: d.sd_ctl_r = reg_wdata;
                `VIM_REG_SD_FMT: d.sd_fmt_r = reg_wdata;
                default: ;
            endcase
        end

        // register reads, data in the following cycle only
        d.rdata = `VIM_REG_RESET;
        if (reg_rd) begin
            unique case (reg_addr)
                `VIM_REG_MODE: d.rdata = q.mode_r;
                `VIM_REG_HD_FMT: d.rdata = q.hd_fmt_r;
                `VIM_REG_HD_CTL: d.rdata = q.hd_ctl_r;
                `VIM_REG_SD_CTL: d.rdata = q.sd_ctl_r;
                `VIM_REG_SD_FMT: d.rdata = q.sd_fmt_r;
                `VIM_REG_STATUS: d.rdata = {q.pa[1], q.pb[1], q.ddr_have,
                                            q.ext_sync, 1'b0, 3'(mode)};
                default: d.rdata = `VIM_REG_RESET;
            endcase
        end

        // wide and rgb SD modes rely on the sync pins alone
        d.ext_sync = (mode == VIM_M_SD) && (sd_rgb || sd_wide); // RULE_09

        // sd path, one word set per rising primary edge
        if (sd_on && pa_rise) begin // RULE_22
            d.sd_valid = 1'b1;
            d.sd_syn = q.syn_s[4:3]; // RULE_09
            d.sd_ch1 = '0;
            d.sd_ch2 = '0;
            if (mode != VIM_M_SD) begin
                d.sd_ch0 = fit(q.s_s, sd_ten); // RULE_19 RULE_20
            end else if (sd_rgb) begin
                d.sd_ch0 = fit(q.s_s, sd_ten); // RULE_07
                d.sd_ch1 = fit(q.y_s, sd_ten); // RULE_07
                d.sd_ch2 = fit(q.c_s, sd_ten); // RULE_07 RULE_08
            end else if (sd_wide) begin
                d.sd_ch0 = fit(swap ? q.y_s : q.s_s, sd_ten); // RULE_06
                d.sd_ch1 = fit(swap ? q.c_s : q.y_s, sd_ten); // RULE_06
            end else begin
                d.sd_ch0 = fit(swap ? q.y_s : q.s_s, sd_ten); // RULE_05 RULE_08
            end
        end

        // ed/hd dual rate: Y on one edge, CrCb on the other
        if (hd_on && hd_ddr) begin // RULE_13
            if (y_edge) begin
                d.ddr_y = fit(q.y_s, hd_ten); // RULE_15 RULE_20
                d.ddr_have = 1'b1;
            end else if (c_edge && q.ddr_have) begin
                d.hd_ch0 = q.ddr_y;
                d.hd_ch1 = fit(q.y_s, hd_ten); // RULE_15 RULE_20
                d.hd_ch2 = '0;
                d.hd_valid = 1'b1;
                d.hd_syn = q.syn_s[2:0];
                d.ddr_have = 1'b0;
            end
        end else if (hd_on && hd_rise) begin // RULE_22
            d.ddr_have = 1'b0;
            d.hd_valid = 1'b1;
            d.hd_syn = q.syn_s[2:0];
            d.hd_ch1 = '0;
            d.hd_ch2 = '0;
            if (mode == VIM_M_ED54) begin
                d.hd_ch0 = fit(q.y_s, hd_ten); // RULE_21
            end else if (mode == VIM_M_SD_HD_SDR) begin
                d.hd_ch0 = fit(q.y_s, hd_ten); // RULE_19
                d.hd_ch1 = fit(q.c_s, hd_ten); // RULE_19
            end else if (hd_rgb) begin
                d.hd_ch0 = fit(q.s_s, hd_ten); // RULE_17 RULE_13
                d.hd_ch1 = fit(q.y_s, hd_ten); // RULE_17
                d.hd_ch2 = fit(q.c_s, hd_ten); // RULE_17
            end else if (hd_422) begin
                d.hd_ch0 = fit(q.y_s, hd_ten); // RULE_14
                d.hd_ch1 = fit(q.c_s, hd_ten); // RULE_14
            end else begin
                d.hd_ch0 = fit(q.y_s, hd_ten); // RULE_16
                d.hd_ch1 = fit(q.s_s, hd_ten); // RULE_16
                d.hd_ch2 = fit(q.c_s, hd_ten); // RULE_16
            end
        end else if (!hd_on) begin
            d.ddr_have = 1'b0;
        end
    end

    // ==========================================================
    // state register; all zero selects SD only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0; // RULE_02
            q.sd_syn <= 2'h3;
            q.hd_syn <= 3'h7;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign reg_rdata = q.rdata;
    assign sd_ch0 = q.sd_ch0;
    assign sd_ch1 = q.sd_ch1;
    assign sd_ch2 = q.sd_ch2;
    assign sd_valid = q.sd_valid;
    assign {sd_hsync_n, sd_vsync_n} = q.sd_syn;
    assign sd_ext_sync = q.ext_sync;
    assign hd_ch0 = q.hd_ch0;
    assign hd_ch1 = q.hd_ch1;
    assign hd_ch2 = q.hd_ch2;
    assign hd_valid = q.hd_valid;
    assign {hd_hsync_n, hd_vsync_n, hd_blank_n} = q.hd_syn;

endmodule : vim_device

`default_nettype wire

// ---- vim_map.svh ----
/*
 * constants of the video input port mode mux: register offsets, field
 * positions, mode codes and link timing.
 * assumes it is included by bare name from the package and both ends.
 */
// How it works
// RULE_01 - mode from bits 6..4 of 0x01
// RULE_02 - reset selects mode 000, SD only
// RULE_03 - codes 000,001,010,011,100,111 decode the modes
// RULE_04 - SD only: source gives 27 MHz, SD syncs (the source here divides its clock to an 80 ns, 12.5 MHz pixel clock)
// RULE_05 - SD 8/10-bit on first bus, swap takes second
// RULE_06 - SD 16/20-bit: Y and CrCb, swap shifts buses
// RULE_07 - SD RGB: red, green, blue on three buses
// RULE_08 - 8-bit widths drop the two low lines
// RULE_09 - wide SD modes use external syncs only
// RULE_10 - SD width and format from 0x88
// RULE_11 - ED/HD width from 0x33 bit 2
// RULE_12 - ED/HD only: source gives clock and syncs
// RULE_13 - DDR only 4:2:2; RGB only single rate
// RULE_14 - HD SDR 4:2:2: Y second, CrCb third bus
// RULE_15 - HD DDR: Y, CrCb on opposite edges
// RULE_16 - HD 4:4:4 YCrCb: Y second, Cr first, Cb third
// RULE_17 - HD RGB: red, green, blue on three buses
// RULE_18 - simultaneous: SD on primary, HD on secondary
// RULE_19 - simultaneous SDR: SD first, HD Y second, CrCb third
// RULE_20 - simultaneous DDR: SD first, HD DDR second bus
// RULE_21 - ED 54: interleaved YCrCb on second bus
// RULE_22 - SDR words taken once per active edge
`ifndef VIM_MAP_SVH
`define VIM_MAP_SVH

// ==========================================================
// register offsets
`define VIM_REG_MODE 8'h01
`define VIM_REG_HD_FMT 8'h33
`define VIM_REG_HD_CTL 8'h35
`define VIM_REG_SD_CTL 8'h87
`define VIM_REG_SD_FMT 8'h88
`define VIM_REG_STATUS 8'h40
`define VIM_REG_RESET 8'h00

// ==========================================================
// field positions
`define VIM_MODE_MSB 6
`define VIM_MODE_LSB 4
`define VIM_SWAP_BIT 7
`define VIM_EDGE_MSB 2
`define VIM_EDGE_LSB 1
`define VIM_EDGE_Y_RISE 2'h0
`define VIM_HD_WIDTH_BIT 2
`define VIM_HD_422_BIT 6
`define VIM_HD_RGB_BIT 1
`define VIM_SD_RGB_BIT 7
`define VIM_SD_WIDTH_BIT 4
`define VIM_SD_WIDE_BIT 3

// ==========================================================
// mode codes
`define VIM_CODE_SD 3'h0
`define VIM_CODE_HD_SDR 3'h1
`define VIM_CODE_HD_DDR 3'h2
`define VIM_CODE_SD_HD_SDR 3'h3
`define VIM_CODE_SD_HD_DDR 3'h4
`define VIM_CODE_ED54 3'h7

// ==========================================================
// buses and link timing
`define VIM_BUS_W 10
`define VIM_REG_W 8
`define VIM_SYS_PERIOD_NS 10
`define VIM_LINK_PERIOD_NS 80
`define VIM_DIV_HALF 3'((`VIM_LINK_PERIOD_NS / `VIM_SYS_PERIOD_NS) / 2)
`define VIM_DIV_MID 3'((`VIM_LINK_PERIOD_NS / `VIM_SYS_PERIOD_NS) / 4)
`define VIM_DIV_LAST 3'((`VIM_LINK_PERIOD_NS / `VIM_SYS_PERIOD_NS) - 1)

`endif

// ---- vim_pkg.sv ----
/*
 * types shared by both ends of the video input port mode mux.
 * assumes vim_map.svh is on the include path.
 */
`default_nettype none
`include "vim_map.svh"

package vim_pkg;

    typedef logic [`VIM_BUS_W-1:0] vim_word_type;
    typedef logic [`VIM_REG_W-1:0] vim_byte_type;

    // decoded input modes
    typedef enum logic [2:0] {
        VIM_M_SD,
        VIM_M_HD_SDR,
        VIM_M_HD_DDR,
        VIM_M_SD_HD_SDR,
        VIM_M_SD_HD_DDR,
        VIM_M_ED54,
        VIM_M_NONE
    } vim_mode_type;

    // whole state of the device end
    typedef struct packed {
        vim_byte_type mode_r;
        vim_byte_type hd_fmt_r;
        vim_byte_type hd_ctl_r;
        vim_byte_type sd_ctl_r;
        vim_byte_type sd_fmt_r;
        vim_byte_type rdata;
        logic [2:0] pa;
        logic [2:0] pb;
        vim_word_type s_m, s_s, y_m, y_s, c_m, c_s;
        logic [4:0] syn_m, syn_s;
        vim_word_type sd_ch0, sd_ch1, sd_ch2;
        logic sd_valid;
        logic [1:0] sd_syn;
        vim_word_type hd_ch0, hd_ch1, hd_ch2;
        logic hd_valid;
        logic [2:0] hd_syn;
        vim_word_type ddr_y;
        logic ddr_have;
        logic ext_sync;
    } vim_dev_state_type;

    // whole state of the source end
    typedef struct packed {
        logic [2:0] cnt;
        logic pa, pb;
        vim_word_type s, y, c;
        logic [4:0] syn;
        logic take;
    } vim_src_state_type;

endpackage : vim_pkg

`default_nettype wire

// ---- vim_if.sv ----
/*
 * pins between a video source and the encoder input port.
 * assumes both ends run off their own system clocks.
 */
`default_nettype none

interface vim_if;
    import vim_pkg::*;
    logic primary_pixel_clock_in;
    logic secondary_pixel_clock_in;
    vim_word_type s_bus, y_bus, c_bus;
    logic sd_hsync_n, sd_vsync_n;
    logic hd_hsync_n, hd_vsync_n, hd_blank_n;

    modport device (
        input primary_pixel_clock_in, secondary_pixel_clock_in,
        input s_bus, y_bus, c_bus,
        input sd_hsync_n, sd_vsync_n, hd_hsync_n, hd_vsync_n, hd_blank_n
    );
    modport source (
        output primary_pixel_clock_in, secondary_pixel_clock_in,
        output s_bus, y_bus, c_bus,
        output sd_hsync_n, sd_vsync_n, hd_hsync_n, hd_vsync_n, hd_blank_n
    );
endinterface : vim_if

`default_nettype wire

// ---- vim_source.sv ----
/*
 * source end: makes the pixel clocks by dividing its own clock and
 * drives the pixel buses and sync pins.
 * assumes the user presents a new word set after each take pulse.
 */
`default_nettype none
`include "vim_map.svh"

module vim_source
    import vim_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst_n,
    // link
    vim_if.source link,
    // user side
    input wire logic sec_clock_en,
    input var vim_word_type pix_s,
    input var vim_word_type pix_y,
    input var vim_word_type pix_c,
    input wire logic [1:0] sd_syn_n,
    input wire logic [2:0] hd_syn_n,
    output logic take
);

    vim_src_state_type q, d;

    // ==========================================================
    // divider and data launch between clock edges
    always_comb begin
        d = q;
        d.take = 1'b0;
        d.cnt = q.cnt + 3'h1;
        d.pa = (d.cnt < `VIM_DIV_HALF); // RULE_04 RULE_12 RULE_21
        d.pb = sec_clock_en & d.pa; // RULE_18
        if (d.cnt == `VIM_DIV_MID ||
            d.cnt == `VIM_DIV_HALF + `VIM_DIV_MID) begin
            d.s = pix_s;
            d.y = pix_y;
            d.c = pix_c;
            d.syn = {sd_syn_n, hd_syn_n}; // RULE_09
            d.take = 1'b1;
        end
    end

    // state register, syncs idle high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.syn <= 5'h1F;
            q.cnt <= `VIM_DIV_LAST; // wraps to zero: first period whole
        end else begin
            q <= d;
        end
    end

    // pins straight from flops
    assign link.primary_pixel_clock_in = q.pa;
    assign link.secondary_pixel_clock_in = q.pb;
    assign link.s_bus = q.s;
    assign link.y_bus = q.y;
    assign link.c_bus = q.c;
    assign {link.sd_hsync_n, link.sd_vsync_n} = q.syn[4:3];
    assign {link.hd_hsync_n, link.hd_vsync_n, link.hd_blank_n} = q.syn[2:0];
    assign take = q.take;

endmodule : vim_source

`default_nettype wire

// ---- vim_checker.sv ----
/*
 * checker: timing of the link pins between source and device.
 * assumes clock and rst_n of the source end and the 80 ns link period.
 */
`default_nettype none

module vim_checker
    import vim_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst_n,
    // link clocks
    input wire logic primary_pixel_clock_in,
    input wire logic secondary_pixel_clock_in,
    // link data and syncs
    input var vim_word_type s_bus,
    input var vim_word_type y_bus,
    input var vim_word_type c_bus,
    input wire logic sd_hsync_n,
    input wire logic sd_vsync_n,
    input wire logic hd_hsync_n,
    input wire logic hd_vsync_n,
    input wire logic hd_blank_n
);
    // ==========================================================
    // pin checks
    wire logic p;
    wire logic sec;
    wire logic [29:0] dat;
    wire logic [4:0] syn;

    // short names for the watched pins
    assign p = primary_pixel_clock_in;
    assign sec = secondary_pixel_clock_in;
    assign dat = {s_bus, y_bus, c_bus};
    assign syn = {sd_hsync_n, sd_vsync_n, hd_hsync_n, hd_vsync_n, hd_blank_n};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_pclk_period: assert property (
        $rose(p) |=> !$rose(p) [*7] ##1 $rose(p))
        else $error("primary clock period is not 8 cycles");
    a_pclk_half: assert property (
        $rose(p) |-> ##[3:5] $fell(p))
        else $error("primary clock high phase out of range");
    a_data_settled: assert property (
        $changed(p) |-> $stable(dat) && $past(dat, 1) == $past(dat, 2))
        else $error("pixel data moved next to a clock edge");
    a_data_mid_half: assert property (
        $changed(dat) |-> $stable(p) ##1 $stable(p))
        else $error("pixel data changed near a clock edge");
    a_word_hold: assert property (
        $changed(y_bus) |=> $stable(y_bus) [*3])
        else $error("pixel word held under 4 cycles");
    a_sync_settled: assert property (
        $changed(p) |-> $stable(syn))
        else $error("sync pins moved at a clock edge");
    a_sec_in_phase: assert property (
        sec |-> p)
        else $error("secondary clock out of phase");
    a_reset_idle: assert property (disable iff (1'b0)
        !rst_n |=> !p && !sec && dat == 30'h0 && syn == 5'h1F)
        else $error("link pins not idle in reset");
endmodule : vim_checker

`default_nettype wire

// ---- testbench.sv ----
/*
 * testbench: source and device joined by one link; pixel words, syncs
 * and registers driven here, channels checked per mode.
 * assumes a 100 MHz clock and the 80 ns link period of the source.
 */
`default_nettype none

module testbench
    import vim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sec_en = 1'b0, take, wr = 1'b0, rd = 1'b0;
    vim_word_type ps = '0, py = '0, pc = '0, yh = '0;
    logic [1:0] ssn = 2'h3, ed = 2'h0;
    logic [2:0] hsn = 3'h7, md = 3'h0;
    logic [7:0] ra = 8'h00;
    vim_byte_type rw = 8'h00, rdat;
    vim_word_type s0, s1, s2, h0, h1, h2;
    logic sv, sh, svs, sx, hv, hh, hvs, hb, rdp = 1'b0;
    logic sw, srgb, swide, s10, h422, h10, hrgb, on = 1'b0, arm = 1'b0;
    logic [39:0] sdq[$], hdq[$], rq[$], e;
    logic [2:0] ml [0:11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2,
        3'h3, 3'h4, 3'h4, 3'h7, 3'h5};
    int seed = 32'h43f87cba, n_fail = 0, n_tests = 0, nt = 0;
    time t0 = 0;
    vim_if lnk();

    always #5 clock = ~clock;

    // ==========================================================
    // both ends and the checker
    vim_source i_vim_source (.clock(clock), .rst_n(rst_n),
        .link(lnk.source), .sec_clock_en(sec_en), .pix_s(ps), .pix_y(py),
        .pix_c(pc), .sd_syn_n(ssn), .hd_syn_n(hsn), .take(take));
    vim_device i_vim_device (.clock(clock), .rst_n(rst_n),
        .link(lnk.device), .reg_addr(ra), .reg_wdata(rw), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .sd_ch0(s0), .sd_ch1(s1),
        .sd_ch2(s2), .sd_valid(sv), .sd_hsync_n(sh), .sd_vsync_n(svs),
        .sd_ext_sync(sx), .hd_ch0(h0), .hd_ch1(h1), .hd_ch2(h2),
        .hd_valid(hv), .hd_hsync_n(hh), .hd_vsync_n(hvs), .hd_blank_n(hb));
    vim_checker i_vim_checker (.clock(clock), .rst_n(rst_n),
        .primary_pixel_clock_in(lnk.primary_pixel_clock_in),
        .secondary_pixel_clock_in(lnk.secondary_pixel_clock_in),
        .s_bus(lnk.s_bus), .y_bus(lnk.y_bus), .c_bus(lnk.c_bus),
        .sd_hsync_n(lnk.sd_hsync_n), .sd_vsync_n(lnk.sd_vsync_n),
        .hd_hsync_n(lnk.hd_hsync_n), .hd_vsync_n(lnk.hd_vsync_n),
        .hd_blank_n(lnk.hd_blank_n));

    // ==========================================================
    // helpers
    function automatic vim_word_type wm(vim_word_type v, logic t);
        return t ? v : {v[9:2], 2'h0};
    endfunction : wm

    task automatic chk(logic [39:0] x, logic [39:0] g);
        n_tests++;
        if (x !== g) begin
            n_fail++;
            $display("[ERR] %0t exp %h got %h", $time, x, g);
        end
    endtask : chk

    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // expected channels of the words just put on the pins
    task automatic note(logic od);
        logic dd;
        dd = md == 3'h2 || md == 3'h4;
        if (!od && md == 3'h0)
            sdq.push_back(srgb ? {ssn, wm(ps, s10), wm(py, s10), wm(pc, s10)}
                : swide ? {ssn, wm(sw ? py : ps, s10), wm(sw ? pc : py, s10),
                10'h0} : {ssn, wm(sw ? py : ps, s10), 20'h0});
        if (!od && (md == 3'h3 || md == 3'h4))
            sdq.push_back({ssn, wm(ps, s10), 20'h0});
        if (!od && md == 3'h1)
            hdq.push_back(hrgb ? {hsn, wm(ps, h10), wm(py, h10), wm(pc, h10)}
                : h422 ? {hsn, wm(py, h10), wm(pc, h10), 10'h0}
                : {hsn, wm(py, h10), wm(ps, h10), wm(pc, h10)});
        if (!od && (md == 3'h3 || md == 3'h7))
            hdq.push_back({hsn, wm(py, h10), md[2] ? 10'h0 : wm(pc, h10),
                10'h0});
        if (dd && od == (ed != 2'h0))
            yh = wm(py, h10);
        else if (dd)
            hdq.push_back({hsn, yh, wm(py, h10), 10'h0});
    endtask : note

    task automatic wreg(logic [7:0] a, vim_byte_type d);
        ra <= a;
        rw <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wreg

    task automatic rreg(logic [7:0] a, vim_byte_type x);
        rq.push_back(x);
        ra <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
    endtask : rreg

    // one mode with random format bits, then a stretch of traffic
    task automatic run_cfg(logic [2:0] m);
        on <= 1'b0;
        @(posedge clock);
        {sw, ed, srgb, swide, s10, h422, h10, hrgb} = 9'($random(seed));
        md = m;
        ssn <= 2'($random(seed));
        hsn <= 3'($random(seed));
        sec_en <= m == 3'h3 || m == 3'h4;
        wreg(8'h01, {sw, m, 1'b0, ed, 1'b0});
        wreg(8'h33, {1'b0, h422, 3'h0, h10, 2'h0});
        wreg(8'h35, {6'h0, hrgb, 1'b0});
        wreg(8'h87, {srgb, 7'h0});
        wreg(8'h88, {3'h0, s10, swide, 3'h0});
        rreg(8'h01, {sw, m, 1'b0, ed, 1'b0}); // mode field
        repeat (16) @(posedge clock);
        chk(m == 3'h0 && (srgb || swide), sx); // sync source
        sdq.delete();
        hdq.delete();
        arm = 1'b1;
        repeat (160) @(posedge clock);
        chk(sdq.size() < 3, 1'b1); // sd captures kept up
        chk(hdq.size() < 3, 1'b1); // hd captures kept up
    endtask : run_cfg

    // ==========================================================
    // pixel driver: new words after each take, notes made as they go
    always @(posedge clock) begin
        if (!rst_n)
            nt = 0;
        else if (take === 1'b1) begin
            nt++;
            if (arm && nt[0] == ((md == 3'h2 || md == 3'h4) && ed != 2'h0)) begin
                on = 1'b1;
                arm = 1'b0;
                t0 = $time;
            end
            if (on)
                note(nt[0]);
            ps <= vim_word_type'($random(seed));
            py <= vim_word_type'($random(seed));
            pc <= vim_word_type'($random(seed));
        end
    end

    // monitor: each capture or read against the oldest note
    always @(posedge clock) begin
        if (on && $time - t0 > 45 && sv === 1'b1) begin
            e = sdq.size() ? sdq.pop_front() : '1;
            chk(e, {sh, svs, s0, s1, s2}); // sd map
        end
        if (on && $time - t0 > 45 && hv === 1'b1) begin
            e = hdq.size() ? hdq.pop_front() : '1;
            chk(e, {hh, hvs, hb, h0, h1, h2}); // hd map
        end
        if (rdp)
            chk(rq.pop_front(), rdat); // read back
        rdp = rd;
    end

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rreg(8'h01, 8'h00); // power-up mode
        wreg(8'h77, 8'h5A);
        rreg(8'h77, 8'h00);
        foreach (ml[i])
            run_cfg(ml[i]); // every mode code
        end_of_test();
    end

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
